//--- rtl/uimb_defines.svh
`ifndef UIMB_DEFINES_SVH
`define UIMB_DEFINES_SVH

// register byte addresses
`define UIMB_ADDR_MASK        12'h038
`define UIMB_ADDR_RAW         12'h03C
`define UIMB_ADDR_MASKED      12'h040

// field positions in the mask, raw and masked words
`define UIMB_BIT_RX           4
`define UIMB_BIT_TX           5
`define UIMB_BIT_RT           6
`define UIMB_BIT_FE           7
`define UIMB_BIT_PE           8
`define UIMB_BIT_BE           9
`define UIMB_BIT_OE           10
`define UIMB_SRC_LSB          4
`define UIMB_SRC_MSB          10

// reset value of the writable mask field
`define UIMB_MASK_RESET       7'h00
// reserved low field reads as this
`define UIMB_RSVD_LOW_VALUE   4'h0

`endif

//--- rtl/uimb_pkg.sv
package uimb_pkg;
    typedef logic [6:0]  uimb_src_t;
    typedef logic [31:0] uimb_word_t;
    typedef logic [11:0] uimb_addr_t;
    typedef enum logic [1:0] {
        UIMB_SEL_MASK,
        UIMB_SEL_RAW,
        UIMB_SEL_MASKED,
        UIMB_SEL_NONE
    } uimb_sel_t;
endpackage

//--- rtl/uimb_gate_if.sv
`timescale 1ns/1ps
interface uimb_gate_if;
    import uimb_pkg::*;
    uimb_src_t raw;
    uimb_src_t mask;
    uimb_src_t masked;
    logic      irq;
    modport ctrl (output raw, output mask, input masked, input irq);
    modport gate (input raw, input mask, output masked, output irq);
endinterface

//--- rtl/uimb_gate.sv
`timescale 1ns/1ps
module uimb_gate
    import uimb_pkg::*;
(
    uimb_gate_if.gate g
);
    // per-source and, then one or line
    assign g.masked = g.raw & g.mask; // R8 R10
    assign g.irq    = |g.masked;      // R10
endmodule // uimb_gate

//--- rtl/uimb_mask_bank.sv
// Overview of operation
// [R1] break-error mask, bit 9, r/w, reset 0
// [R2] parity-error mask, bit 8, r/w, reset 0
// [R3] framing-error mask, bit 7, reset 0
// [R4] receive-timeout mask, bit 6, r/w, reset 0
// [R5] transmit mask, bit 5, r/w, reset 0
// [R6] receive mask, bit 4, r/w, reset 0
// [R7] bits 3:0 reserved, read zero
// [R8] clear mask blocks its raw interrupt
// [R9] overrun-error mask, bit 10, r/w, reset 0
// [R10] or of each raw bit anded with mask
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "uimb_defines.svh"
module uimb_mask_bank (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire uimb_pkg::uimb_addr_t paddr,
    input  wire uimb_pkg::uimb_word_t pwdata,
    output      uimb_pkg::uimb_word_t prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire uimb_pkg::uimb_src_t  raw_irq,
    output      uimb_pkg::uimb_src_t  masked_irq,
    output logic                     uart_irq
);
    import uimb_pkg::*;

    uimb_src_t  mask_ff;
    uimb_src_t  nxt_mask;
    uimb_word_t prdata_ff;
    uimb_word_t nxt_prdata;
    uimb_src_t  masked_ff;
    logic       irq_ff;
    logic       err_ff;
    logic       nxt_err;
    uimb_sel_t  sel;
    logic       setup;
    uimb_gate_if gi ();

    function automatic uimb_sel_t decode(input uimb_addr_t a);
        unique case (a)
            `UIMB_ADDR_MASK:   decode = UIMB_SEL_MASK;
            `UIMB_ADDR_RAW:    decode = UIMB_SEL_RAW;
            `UIMB_ADDR_MASKED: decode = UIMB_SEL_MASKED;
            default:           decode = UIMB_SEL_NONE;
        endcase
    endfunction

    function automatic uimb_word_t place(input uimb_src_t v);
        // reserved fields above and below read zero
        place = {21'h000000, v, `UIMB_RSVD_LOW_VALUE}; // R7
    endfunction

    assign gi.raw  = raw_irq;
    assign gi.mask = mask_ff;
    uimb_gate u_gate (.g(gi.gate));

    // no wait states: read data fetched in setup
    assign setup   = psel & ~penable;
    assign sel     = decode(paddr);
    assign pready  = 1'b1;
    assign pslverr = err_ff;
    assign prdata  = prdata_ff;
    assign masked_irq = masked_ff;
    assign uart_irq   = irq_ff;

    always_comb begin
        nxt_mask   = mask_ff;
        nxt_prdata = prdata_ff;
        nxt_err    = err_ff;
        if (psel & penable & pwrite & (sel == UIMB_SEL_MASK)) begin
            // all seven mask bits, reserved bits dropped
            nxt_mask = pwdata[`UIMB_SRC_MSB:`UIMB_SRC_LSB]; // R1 R2 R3 R4 R5 R6 R9
        end
        if (setup) begin
            nxt_err = (sel == UIMB_SEL_NONE);
            unique case (sel)
                UIMB_SEL_MASK:   nxt_prdata = place(mask_ff); // R1 R2 R3 R4 R5 R6 R9
                UIMB_SEL_RAW:    nxt_prdata = place(raw_irq);
                UIMB_SEL_MASKED: nxt_prdata = place(gi.masked);
                UIMB_SEL_NONE:   nxt_prdata = 32'h00000000;
            endcase
            if (pwrite) begin
                nxt_prdata = 32'h00000000;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_ff   <= `UIMB_MASK_RESET; // R1 R2 R3 R4 R5 R6 R9
            prdata_ff <= 32'h00000000;
            err_ff    <= 1'b0;
            masked_ff <= 7'h00;
            irq_ff    <= 1'b0;
        end else begin
            mask_ff   <= nxt_mask;
            prdata_ff <= nxt_prdata;
            err_ff    <= nxt_err;
            masked_ff <= gi.masked; // R8 R10
            irq_ff    <= gi.irq;    // R10
        end
    end

    property p_mask_write;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && pwrite && paddr == `UIMB_ADDR_MASK)
        |=> (mask_ff == $past(pwdata[10:4]));
    endproperty
    a_mask_write: assert property (p_mask_write) // R1
        else $error("mask write not stored");

    property p_mask_hold;
        @(posedge pclk) disable iff (!presetn)
        !(psel && penable && pwrite && paddr == `UIMB_ADDR_MASK)
        |=> $stable(mask_ff);
    endproperty
    a_mask_hold: assert property (p_mask_hold) // R2
        else $error("mask changed without write");

    property p_read_back;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && paddr == `UIMB_ADDR_MASK)
        |=> (prdata[10:4] == $past(mask_ff));
    endproperty
    a_read_back: assert property (p_read_back) // R3
        else $error("mask readback wrong");

    property p_rsvd_zero;
        @(posedge pclk) disable iff (!presetn)
        (prdata[3:0] == 4'h0) && (prdata[31:11] == 21'h000000);
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) // R7
        else $error("reserved bits not zero");

    property p_block;
        @(posedge pclk) disable iff (!presetn)
        (mask_ff == 7'h00) |=> !uart_irq;
    endproperty
    a_block: assert property (p_block) // R8
        else $error("irq with all masks clear");

    property p_overrun;
        @(posedge pclk) disable iff (!presetn)
        (raw_irq[6] && mask_ff[6]) |=> uart_irq && masked_irq[6];
    endproperty
    a_overrun: assert property (p_overrun) // R9
        else $error("overrun not forwarded");

    property p_and_or;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> (masked_irq == $past(raw_irq & mask_ff))
            && (uart_irq == |$past(raw_irq & mask_ff));
    endproperty
    a_and_or: assert property (p_and_or) // R10
        else $error("masked request mismatch");

    property p_rx_tx;
        @(posedge pclk) disable iff (!presetn)
        (raw_irq[1:0] != 2'b00 && mask_ff[1:0] == 2'b00
            && raw_irq[6:2] == 5'h00) |=> !uart_irq;
    endproperty
    a_rx_tx: assert property (p_rx_tx) // R6
        else $error("unmasked rx or tx leaked");

    property p_break_fwd;
        @(posedge pclk) disable iff (!presetn)
        (raw_irq[5] && mask_ff[5])
        |=> uart_irq && masked_irq[5];
    endproperty
    a_break_fwd: assert property (p_break_fwd) // R1
        else $error("break error not forwarded");

    property p_parity_fwd;
        @(posedge pclk) disable iff (!presetn)
        (raw_irq[4] && mask_ff[4])
        |=> uart_irq && masked_irq[4];
    endproperty
    a_parity_fwd: assert property (p_parity_fwd) // R2
        else $error("parity error not forwarded");

    property p_framing_fwd;
        @(posedge pclk) disable iff (!presetn)
        (raw_irq[3] && mask_ff[3])
        |=> uart_irq && masked_irq[3];
    endproperty
    a_framing_fwd: assert property (p_framing_fwd) // R3
        else $error("framing error not forwarded");

    property p_timeout_fwd;
        @(posedge pclk) disable iff (!presetn)
        (raw_irq[2] && mask_ff[2])
        |=> uart_irq && masked_irq[2];
    endproperty
    a_timeout_fwd: assert property (p_timeout_fwd) // R4
        else $error("receive timeout not forwarded");

    property p_transmit_fwd;
        @(posedge pclk) disable iff (!presetn)
        (raw_irq[1] && mask_ff[1])
        |=> uart_irq && masked_irq[1];
    endproperty
    a_transmit_fwd: assert property (p_transmit_fwd) // R5
        else $error("transmit request not forwarded");

    property p_receive_fwd;
        @(posedge pclk) disable iff (!presetn)
        (raw_irq[0] && mask_ff[0])
        |=> uart_irq && masked_irq[0];
    endproperty
    a_receive_fwd: assert property (p_receive_fwd) // R6
        else $error("receive request not forwarded");

    property p_block_each;
        @(posedge pclk) disable iff (!presetn)
        1'b1
        |=> ((masked_irq & ~$past(mask_ff)) == 7'h00);
    endproperty
    a_block_each: assert property (p_block_each) // R8
        else $error("masked source with clear mask");

    property p_reset_clear;
        @(posedge pclk)
        !presetn |=> (mask_ff == `UIMB_MASK_RESET) && !uart_irq
            && (masked_irq == 7'h00) && (prdata == 32'h00000000);
    endproperty
    a_reset_clear: assert property (p_reset_clear) // R9
        else $error("state not cleared by reset");

endmodule // uimb_mask_bank

//--- verification/uimb_src_model.sv
`timescale 1ns/1ps
module uimb_src_model (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                ld,
    input  wire uimb_pkg::uimb_src_t val,
    output      uimb_pkg::uimb_src_t raw_irq
);
    import uimb_pkg::*;

    uimb_src_t raw_ff;
    uimb_src_t nxt_raw;
    // level sources, held until the next load
    always_comb begin
        nxt_raw = ld ? val : raw_ff;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            raw_ff <= 7'h00;
        else
            raw_ff <= nxt_raw;
    end
    assign raw_irq = raw_ff;
endmodule // uimb_src_model

//--- verification/uart_interrupt_mask_bank_tb_top.sv
`timescale 1ns/1ps
`include "uimb_defines.svh"
module uart_interrupt_mask_bank_tb_top;
    import uimb_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        uart_irq, ld;
    uimb_addr_t  paddr;
    uimb_word_t  pwdata, prdata;
    uimb_src_t   raw_irq, masked_irq, val, m, rv;
    logic [32:0] q[$];
    logic [31:0] seed;
    int          n_mismatch, check_count;
    uimb_mask_bank dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .raw_irq(raw_irq), .masked_irq(masked_irq), .uart_irq(uart_irq));
    uimb_src_model src (.pclk(pclk), .presetn(presetn), .ld(ld),
        .val(val), .raw_irq(raw_irq));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic apb(input logic w, input uimb_addr_t a, input uimb_word_t d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input uimb_addr_t a, input logic [32:0] e);
        q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic wrm(input uimb_word_t v);
        m = v[10:4];
        apb(1'b1, `UIMB_ADDR_MASK, v);
        repeat (2) @(posedge pclk);
    endtask
    task automatic setraw(input uimb_src_t v);
        rv = v;
        @(posedge pclk);
        ld <= 1'b1;
        val <= v;
        @(posedge pclk);
        ld <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask
    task automatic ck;
        chk({26'h0, masked_irq}, {26'h0, rv & m});
        chk({32'h0, uart_irq}, {32'h0, |(rv & m)});
    endtask
    // read results, oldest note first
    always @(posedge pclk)
        if (psel && penable && pready === 1'b1 && !pwrite)
            chk({pslverr, prdata}, q.pop_front());
    initial begin
        #200000;
        n_mismatch++;
        summarize;
    end
    initial begin
        {presetn, psel, penable, pwrite, ld} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        val = 7'h00;
        m = 7'h00;
        rv = 7'h00;
        seed = 32'h1182;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(`UIMB_ADDR_MASK, 33'h0);
        wrm(32'hFFFFFFFF);
        rd(`UIMB_ADDR_MASK, 33'h7F0);
        setraw(7'h7F);
        for (int i = 0; i < 7; i++) begin
            wrm(32'h10 << i);
            ck();
            rd(`UIMB_ADDR_MASKED, 33'h10 << i);
        end
        wrm(32'h0);
        ck();
        repeat (8) begin
            seed = xs(seed);
            setraw(seed[6:0]);
            wrm(seed);
            ck();
            rd(`UIMB_ADDR_MASK, {1'b0, seed & 32'h7F0});
            rd(`UIMB_ADDR_RAW, {22'h0, rv, 4'h0});
        end
        rd(12'h044, 33'h100000000);
        // a write to the raw word leaves the mask alone
        apb(1'b1, `UIMB_ADDR_RAW, 32'h0);
        rd(`UIMB_ADDR_MASK, {22'h0, m, 4'h0});
        // mid-run reset clears the mask and the outputs
        presetn <= 1'b0;
        rv = 7'h00;
        m = 7'h00;
        repeat (2) @(posedge pclk);
        ck();
        presetn <= 1'b1;
        rd(`UIMB_ADDR_MASK, 33'h0);
        ck();
        @(posedge pclk);
        chk(33'(q.size()), 33'h0);
        summarize;
    end
endmodule // uart_interrupt_mask_bank_tb_top
